// ### verilog/ecs_map.vh
// Constants for the extended-control serial configuration block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef ECS_MAP_VH
`define ECS_MAP_VH

// Frame layout, sent MSB first
`define ECS_FRAME_BITS        32
`define ECS_HEADER            12'h001
`define ECS_HDR_MSB           31
`define ECS_HDR_LSB           20
`define ECS_ADDR_MSB          19
`define ECS_ADDR_LSB          16
`define ECS_DATA_MSB          15
`define ECS_LAST_BIT          5'h1f

// Register addresses (4-bit)
`define ECS_ADDR_OUTPUT_CONFIG    4'h1
`define ECS_ADDR_I_OFFSET         4'h2
`define ECS_ADDR_I_FULLSCALE      4'h3
`define ECS_ADDR_Q_OFFSET         4'ha
`define ECS_ADDR_Q_FULLSCALE      4'hb
`define ECS_ADDR_INTERLEAVE_CTRL  4'hd
`define ECS_ADDR_PHASE_COARSE     4'he
`define ECS_ADDR_PHASE_FINE       4'hf

// Register indices inside the bank
`define ECS_IDX_CFG    3'h0
`define ECS_IDX_IOFS   3'h1
`define ECS_IDX_IFS    3'h2
`define ECS_IDX_QOFS   3'h3
`define ECS_IDX_QFS    3'h4
`define ECS_IDX_ILV    3'h5
`define ECS_IDX_CRS    3'h6
`define ECS_IDX_FIN    3'h7

// output_config fields
`define ECS_CFG_DUTY_STAB     12
`define ECS_CFG_DDR_PHASE     11
`define ECS_CFG_DDR_DISABLE   10
`define ECS_CFG_SWING         9
`define ECS_CFG_SDR_EDGE      8

// Offset and full-scale adjust: 9-bit step field in bits 15..7
`define ECS_ADJ_MSB           15
`define ECS_ADJ_LSB           7

// interleave_control fields
`define ECS_ILV_ENABLE        15
`define ECS_ILV_AUTO_PHASE    14
`define ECS_ILV_SEL_I         13

// Power-on values
`define ECS_RST_CFG           16'hb2ff
`define ECS_RST_OFFSET        16'h007f
`define ECS_RST_FULLSCALE     16'h807f
`define ECS_RST_ILV           16'h3fff
`define ECS_RST_PHASE         16'h0000

`endif

// ### verilog/ecs_config.v
// Control-mode selection and write-only serial register bank of a dual
// converter. Assumes all pins are asynchronous to core_clk_i and that the
// serial clock is much slower than core_clk_i (at least 4 core cycles per
// half period). Tri-level pins arrive as a level plus a "floating" detect.
//
// Operation
// [RQ1] Normal mode: edge pin floating gives double rate, driven gives single rate.
// [RQ2] Extended mode: ddr_disable bit 10 picks rate; host keeps bit 8 zero in DDR.
// [RQ3] Double-rate phase fixed at 0 degrees normally; bit 11 selects it extended.
// [RQ4] Single-rate data edge from edge pin normally; bit 8 selects it extended.
// [RQ5] Swing from swing pin normally; output_swing_select bit 9 when extended.
// [RQ6] Calibration delay from its pin normally; always short in extended mode.
// [RQ7] Range pin sets both channels' range normally; register 3h steps when extended.
// [RQ8] No offset adjust normally; 512 steps from register 2h bits 15..7 extended.
// [RQ9] Interleave by pin on I only normally; by register, I or Q, extended.
// [RQ10] Interleave phase automatic normally; bit 14 of Dh or Eh/Fh extended.
// [RQ11] Extended power-on defaults: DDR, 0 deg, 710 mV, short delay, 700 mV, no offset.
// [RQ12] Host first writes all eight registers, interleave control first with 3fff.
// [RQ13] Serial port accepts frames only in extended mode; registers are write-only.
// [RQ14] Host holds serial_select_n low for the whole access.
// [RQ15] Data captured on each serial clock rising edge; no minimum clock rate.
// [RQ16] Frame is 32 bits MSB first: header 001h, address A3 first, 16 data.
// [RQ17] Next frame may start on the 33rd clock without releasing select.
// [RQ18] Host avoids serial traffic while the converter calibrates.
// [RQ19] Decode 1h,2h,3h,Ah,Bh as listed; 0h and 4h..9h reserved.
// [RQ20] Range pin floating enters extended mode with its defaults.
// [RQ21] Register contents have no effect while in normal mode.
// [RQ22] Host clears interleave enable before writing output_config.
// [RQ23] Control mode selection stays fixed during operation.
// [RQ24] Register updates only after bit 32 of a good-header frame; others discarded.

`timescale 1ns/100ps

`include "ecs_map.vh"

module ecs_config #(
	parameter ADJ_W = 9
) (
	input  wire             core_clk_i,
	input  wire             nrst_i,
	input  wire             serial_shift_clock_i,
	input  wire             serial_input_line_i,
	input  wire             serial_select_n_i,
	input  wire             range_or_extended_select_i,
	input  wire             range_or_extended_float_i,
	input  wire             output_edge_pin_i,
	input  wire             output_edge_float_i,
	input  wire             output_swing_pin_i,
	input  wire             cal_delay_interleave_pin_i,
	output reg              extended_mode_o,
	output reg              ddr_mode_o,
	output reg              ddr_phase_90_o,
	output reg              sdr_rising_edge_o,
	output reg              swing_normal_o,
	output reg              cal_delay_long_o,
	output reg              duty_stabilizer_o,
	output reg              range_normal_o,
	output reg              adjust_enable_o,
	output reg [ADJ_W-1:0]  i_fullscale_o,
	output reg [ADJ_W-1:0]  q_fullscale_o,
	output reg [ADJ_W-1:0]  i_offset_o,
	output reg [ADJ_W-1:0]  q_offset_o,
	output reg              interleave_en_o,
	output reg              interleave_q_sel_o,
	output reg              interleave_auto_phase_o,
	output reg [15:0]       phase_coarse_o,
	output reg [15:0]       phase_fine_o,
	output reg              reg_write_o
);

	// Two-flop synchronisers for every pin, plus a third stage on the clock
	// so its rising edge is found without touching the first flop.
	localparam NPIN = 9;
	wire [NPIN-1:0] pin_raw;
	reg  [NPIN-1:0] pin_s1_q;
	reg  [NPIN-1:0] pin_s2_q;
	reg             sclk_s3_q;

	assign pin_raw = {serial_shift_clock_i, serial_input_line_i, serial_select_n_i,
		range_or_extended_select_i, range_or_extended_float_i, output_edge_pin_i,
		output_edge_float_i, output_swing_pin_i, cal_delay_interleave_pin_i};

	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pin_s1_q  <= {NPIN{1'b0}} | 9'h040;
			pin_s2_q  <= {NPIN{1'b0}} | 9'h040;
			sclk_s3_q <= 1'b0;
		end else begin
			pin_s1_q  <= pin_raw;
			pin_s2_q  <= pin_s1_q;
			sclk_s3_q <= pin_s2_q[8];
		end
	end

	wire sclk_s     = pin_s2_q[8];
	wire serial_input_line_s    = pin_s2_q[7];
	wire sel_n_s    = pin_s2_q[6];
	wire rng_lvl_s  = pin_s2_q[5];
	wire rng_flt_s  = pin_s2_q[4];
	wire edge_lvl_s = pin_s2_q[3];
	wire edge_flt_s = pin_s2_q[2];
	wire swing_s    = pin_s2_q[1];
	wire pin127_s   = pin_s2_q[0];

	// Mode is treated as static; a change simply reselects the source.
	wire ext_mode   = rng_flt_s;                           // [RQ20]
	wire sclk_rise  = sclk_s & ~sclk_s3_q;                 // [RQ15]

	// Address decode, shared by the write path and the reserved check.
	function [3:0] ecs_decode;
		input [3:0] addr;
		begin
			case (addr)                                    // [RQ19]
			`ECS_ADDR_OUTPUT_CONFIG:   ecs_decode = {1'b1, `ECS_IDX_CFG};
			`ECS_ADDR_I_OFFSET:        ecs_decode = {1'b1, `ECS_IDX_IOFS};
			`ECS_ADDR_I_FULLSCALE:     ecs_decode = {1'b1, `ECS_IDX_IFS};
			`ECS_ADDR_Q_OFFSET:        ecs_decode = {1'b1, `ECS_IDX_QOFS};
			`ECS_ADDR_Q_FULLSCALE:     ecs_decode = {1'b1, `ECS_IDX_QFS};
			`ECS_ADDR_INTERLEAVE_CTRL: ecs_decode = {1'b1, `ECS_IDX_ILV};
			`ECS_ADDR_PHASE_COARSE:    ecs_decode = {1'b1, `ECS_IDX_CRS};
			`ECS_ADDR_PHASE_FINE:      ecs_decode = {1'b1, `ECS_IDX_FIN};
			default:                   ecs_decode = 4'h0;
			endcase
		end
	endfunction

	// Serial shifter: 31 earlier bits plus the bit arriving on the 32nd edge.
	reg  [30:0] shift_q;
	reg  [4:0]  bit_cnt_q;
	wire [31:0] frame = {shift_q, serial_input_line_s};
	wire [3:0]  dec   = ecs_decode(frame[`ECS_ADDR_MSB:`ECS_ADDR_LSB]);
	wire        frame_end = sclk_rise && !sel_n_s && ext_mode &&
		(bit_cnt_q == `ECS_LAST_BIT);
	wire        frame_ok  = frame_end &&
		(frame[`ECS_HDR_MSB:`ECS_HDR_LSB] == `ECS_HEADER) && dec[3];

	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			shift_q   <= 31'h00000000;
			bit_cnt_q <= 5'h00;
		end else if (sel_n_s || !ext_mode) begin
			// Releasing select drops a partial frame      [RQ24]
			bit_cnt_q <= 5'h00;                           // [RQ13]
		end else if (sclk_rise) begin
			shift_q   <= frame[30:0];                     // [RQ16]
			bit_cnt_q <= bit_cnt_q + 5'h01;               // [RQ17]
		end
	end

	// Write-only register bank; nothing can be read back.     [RQ13]
	reg [15:0] bank_q [0:7];
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_bank
			localparam [2:0] IDX = gi;
			wire [15:0] rst_val = (gi == 0) ? `ECS_RST_CFG :
				(gi == 1 || gi == 3) ? `ECS_RST_OFFSET :
				(gi == 2 || gi == 4) ? `ECS_RST_FULLSCALE :
				(gi == 5) ? `ECS_RST_ILV : `ECS_RST_PHASE;
			always @(posedge core_clk_i) begin
				if (!nrst_i)
					bank_q[gi] <= rst_val;                  // [RQ11]
				else if (frame_ok && dec[2:0] == IDX)
					bank_q[gi] <= frame[15:0];              // [RQ24]
			end
		end
	endgenerate

	wire [15:0] cfg = bank_q[`ECS_IDX_CFG];
	wire [15:0] ilv = bank_q[`ECS_IDX_ILV];

	// Outputs are resolved from pins in normal mode and from the bank in
	// extended mode, so stale register values never leak out.   [RQ21]
	// One process per output keeps each reset value beside its sources.
	always @(posedge core_clk_i) begin
		if (!nrst_i)
			extended_mode_o <= 1'b0;
		else
			extended_mode_o <= ext_mode;                     // [RQ20]
	end

	// Pulse rises with the bank update, one cycle ahead of the outputs
	always @(posedge core_clk_i) begin
		if (!nrst_i)
			reg_write_o <= 1'b0;
		else
			reg_write_o <= frame_ok;                         // [RQ24]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			ddr_mode_o <= 1'b1;
		else if (ext_mode)
			ddr_mode_o <= ~cfg[`ECS_CFG_DDR_DISABLE];        // [RQ2]
		else
			ddr_mode_o <= edge_flt_s;                        // [RQ1]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			ddr_phase_90_o <= 1'b0;
		else if (ext_mode)
			ddr_phase_90_o <= cfg[`ECS_CFG_DDR_PHASE];       // [RQ3]
		else
			ddr_phase_90_o <= 1'b0;                          // [RQ3]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			sdr_rising_edge_o <= 1'b0;
		else if (ext_mode)
			sdr_rising_edge_o <= cfg[`ECS_CFG_SDR_EDGE];     // [RQ4]
		else
			sdr_rising_edge_o <= edge_lvl_s;                 // [RQ4]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			swing_normal_o <= 1'b1;
		else if (ext_mode)
			swing_normal_o <= cfg[`ECS_CFG_SWING];           // [RQ5]
		else
			swing_normal_o <= swing_s;                       // [RQ5]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			cal_delay_long_o <= 1'b0;
		else if (ext_mode)
			cal_delay_long_o <= 1'b0;                        // [RQ6]
		else
			cal_delay_long_o <= pin127_s;                    // [RQ6]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			duty_stabilizer_o <= 1'b1;
		else if (ext_mode)
			duty_stabilizer_o <= cfg[`ECS_CFG_DUTY_STAB];
		else
			duty_stabilizer_o <= 1'b1;
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			range_normal_o <= 1'b1;
		else if (ext_mode)
			range_normal_o <= 1'b1;
		else
			range_normal_o <= rng_lvl_s;                     // [RQ7]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			adjust_enable_o <= 1'b0;
		else
			adjust_enable_o <= ext_mode;                     // [RQ8]
	end

	// Step fields read as zero in normal mode so nothing downstream trims
	always @(posedge core_clk_i) begin
		if (!nrst_i)
			i_fullscale_o <= {ADJ_W{1'b0}};
		else if (ext_mode)
			i_fullscale_o <= bank_q[`ECS_IDX_IFS][`ECS_ADJ_MSB:`ECS_ADJ_LSB];  // [RQ7]
		else
			i_fullscale_o <= {ADJ_W{1'b0}};
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			q_fullscale_o <= {ADJ_W{1'b0}};
		else if (ext_mode)
			q_fullscale_o <= bank_q[`ECS_IDX_QFS][`ECS_ADJ_MSB:`ECS_ADJ_LSB];  // [RQ7]
		else
			q_fullscale_o <= {ADJ_W{1'b0}};
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			i_offset_o <= {ADJ_W{1'b0}};
		else if (ext_mode)
			i_offset_o <= bank_q[`ECS_IDX_IOFS][`ECS_ADJ_MSB:`ECS_ADJ_LSB];    // [RQ8]
		else
			i_offset_o <= {ADJ_W{1'b0}};
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			q_offset_o <= {ADJ_W{1'b0}};
		else if (ext_mode)
			q_offset_o <= bank_q[`ECS_IDX_QOFS][`ECS_ADJ_MSB:`ECS_ADJ_LSB];    // [RQ8]
		else
			q_offset_o <= {ADJ_W{1'b0}};
	end

	// The same pin sets cal delay and interleave enable in normal mode
	always @(posedge core_clk_i) begin
		if (!nrst_i)
			interleave_en_o <= 1'b0;
		else if (ext_mode)
			interleave_en_o <= ilv[`ECS_ILV_ENABLE];         // [RQ9]
		else
			interleave_en_o <= pin127_s;                     // [RQ9]
	end

	// Normal mode can only interleave the I input
	always @(posedge core_clk_i) begin
		if (!nrst_i)
			interleave_q_sel_o <= 1'b0;
		else if (ext_mode)
			interleave_q_sel_o <= ~ilv[`ECS_ILV_SEL_I];      // [RQ9]
		else
			interleave_q_sel_o <= 1'b0;                      // [RQ9]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			interleave_auto_phase_o <= 1'b1;
		else if (ext_mode)
			interleave_auto_phase_o <= ilv[`ECS_ILV_AUTO_PHASE];  // [RQ10]
		else
			interleave_auto_phase_o <= 1'b1;                 // [RQ10]
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			phase_coarse_o <= 16'h0000;
		else if (ext_mode)
			phase_coarse_o <= bank_q[`ECS_IDX_CRS];          // [RQ10]
		else
			phase_coarse_o <= 16'h0000;
	end

	always @(posedge core_clk_i) begin
		if (!nrst_i)
			phase_fine_o <= 16'h0000;
		else if (ext_mode)
			phase_fine_o <= bank_q[`ECS_IDX_FIN];            // [RQ10]
		else
			phase_fine_o <= 16'h0000;
	end

endmodule

// ### verification/ecs_host_model.sv
// Serial host model driving the three-wire write port.
// Assumes the block samples these lines with its own faster clock.
`timescale 1ns/100ps
module ecs_host_model (
	output logic serial_shift_clock_o,
	output logic serial_input_line_o,
	output logic serial_select_n_o
);
	initial begin
		serial_shift_clock_o = 1'b0;
		serial_input_line_o = 1'b0;
		serial_select_n_o = 1'b1;
	end
	// Sends the top nbits of a frame; never called while calibrating
	// Keep leaves select low so the next frame starts on the 33rd clock
	task automatic send(input logic [31:0] frame, input int nbits, input logic keep);
		serial_select_n_o <= 1'b0;
		for (int i = 31; i > 31 - nbits; i--) begin
			serial_input_line_o <= frame[i];
			#80 serial_shift_clock_o <= 1'b1;
			#80 serial_shift_clock_o <= 1'b0;
		end
		if (!keep) begin
			// Idle data shows the opposite level so a stale bit is never reused
			serial_input_line_o <= ~serial_input_line_o;
			serial_select_n_o <= 1'b1;
			// Release must be seen before any next frame lowers select again
			#160;
		end
	endtask
endmodule

// ### verification/ecs_config_asserts.sv
// Port checker for the serial configuration block.
// Assumes pins stay steady for several core cycles after each change.
`timescale 1ns/100ps
module ecs_config_asserts (
	input wire core_clk_i,
	input wire nrst_i,
	input wire serial_select_n_i,
	input wire range_or_extended_select_i,
	input wire output_edge_float_i,
	input wire output_swing_pin_i,
	input wire extended_mode_o,
	input wire ddr_mode_o,
	input wire ddr_phase_90_o,
	input wire swing_normal_o,
	input wire cal_delay_long_o,
	input wire range_normal_o,
	input wire adjust_enable_o,
	input wire interleave_auto_phase_o,
	input wire reg_write_o
);
	logic [3:0] sel_age_q;
	// Cycles since select was low; a late write means a stray update
	always @(posedge core_clk_i) begin
		if (!serial_select_n_i)
			sel_age_q <= 4'h0;
		else if (sel_age_q != 4'hf)
			sel_age_q <= sel_age_q + 4'h1;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_quiet;
		##1 !reg_write_o ##1 !reg_write_o;
	endsequence
	a_write_one_pulse: assert property ($rose(reg_write_o) |-> s_quiet)
		else $error("write pulse too long");
	a_write_ext_only: assert property (reg_write_o |-> extended_mode_o)
		else $error("write in normal mode");
	a_write_in_frame: assert property (reg_write_o |-> sel_age_q < 4'hc)
		else $error("write long after select release");
	a_ext_fixed_out: assert property (extended_mode_o |-> !cal_delay_long_o && adjust_enable_o)
		else $error("extended mode outputs wrong");
	a_normal_fixed: assert property (!extended_mode_o |->
		!ddr_phase_90_o && !adjust_enable_o && interleave_auto_phase_o)
		else $error("normal mode fixed outputs wrong");
	a_normal_ddr_pin: assert property (!extended_mode_o && $changed(output_edge_float_i) |->
		##[2:4] (ddr_mode_o == output_edge_float_i)) else $error("rate ignores edge pin");
	a_normal_swing_pin: assert property (!extended_mode_o && $changed(output_swing_pin_i) |->
		##[2:4] (swing_normal_o == output_swing_pin_i)) else $error("swing ignores pin");
	a_normal_range_pin: assert property (!extended_mode_o &&
		$changed(range_or_extended_select_i) |->
		##[2:4] (range_normal_o == range_or_extended_select_i)) else $error("range ignores pin");
endmodule
bind ecs_config ecs_config_asserts u_chk (.core_clk_i, .nrst_i, .serial_select_n_i,
	.range_or_extended_select_i, .output_edge_float_i, .output_swing_pin_i, .extended_mode_o,
	.ddr_mode_o, .ddr_phase_90_o, .swing_normal_o, .cal_delay_long_o, .range_normal_o,
	.adjust_enable_o, .interleave_auto_phase_o, .reg_write_o);

// ### verification/ecs_config_test.sv
// Self-checking bench for the serial configuration block.
// Assumes a 20 ns core clock and a host model pacing the link at 160 ns.
`timescale 1ns/100ps
module ecs_config_test;
	logic        core_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        ext = 1'b1;
	logic [4:0]  pins = 5'h00;
	logic [15:0] bank [0:15];
	int          mismatches = 0;
	int          check_count = 0;
	int          pulses = 0;
	int          n;
	wire         sclk, serial_input_line, ssel_n, extended_mode_o, reg_write_o, ddr_mode_o, ddr_phase_90_o;
	wire         sdr_rising_edge_o, swing_normal_o, cal_delay_long_o, duty_stabilizer_o;
	wire         range_normal_o, adjust_enable_o, interleave_en_o, interleave_q_sel_o;
	wire         interleave_auto_phase_o;
	wire [8:0]   i_fullscale_o, q_fullscale_o, i_offset_o, q_offset_o;
	wire [15:0]  phase_coarse_o, phase_fine_o;
	wire [78:0]  seen = {ddr_mode_o, ddr_phase_90_o, sdr_rising_edge_o, swing_normal_o,
		cal_delay_long_o, duty_stabilizer_o, range_normal_o, adjust_enable_o, i_fullscale_o,
		q_fullscale_o, i_offset_o, q_offset_o, interleave_en_o, interleave_q_sel_o,
		interleave_auto_phase_o, phase_coarse_o, phase_fine_o};
	// Rows of {address, data}: interleave control first, all eight, enable cleared before config
	logic [19:0] rows [0:17] = '{20'hd3fff, 20'h1b2ff, 20'h2007f, 20'h3807f, 20'ha007f,
		20'hb807f, 20'he0000, 20'hf0000, 20'h1a8ff, 20'h1b5ff, 20'h2ff80, 20'h30000,
		20'ha8000, 20'hb7f80, 20'hdc000, 20'he1234, 20'hfabcd, 20'hd0000};
	logic [3:0]  resv [0:7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};
	logic [4:0]  pats [0:5] = '{5'h10, 5'h0f, 5'h05, 5'h16, 5'h09, 5'h00};
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (reg_write_o === 1'b1) pulses <= pulses + 1;
	ecs_host_model host (.serial_shift_clock_o(sclk), .serial_input_line_o(serial_input_line),
		.serial_select_n_o(ssel_n));
	ecs_config dut (.core_clk_i, .nrst_i, .serial_shift_clock_i(sclk),
		.serial_input_line_i(serial_input_line), .serial_select_n_i(ssel_n),
		.range_or_extended_select_i(pins[0]), .range_or_extended_float_i(ext),
		.output_edge_pin_i(pins[3]), .output_edge_float_i(pins[4]), .output_swing_pin_i(pins[2]),
		.cal_delay_interleave_pin_i(pins[1]), .extended_mode_o, .ddr_mode_o, .ddr_phase_90_o,
		.sdr_rising_edge_o, .swing_normal_o, .cal_delay_long_o, .duty_stabilizer_o,
		.range_normal_o, .adjust_enable_o, .i_fullscale_o, .q_fullscale_o, .i_offset_o,
		.q_offset_o, .interleave_en_o, .interleave_q_sel_o, .interleave_auto_phase_o,
		.phase_coarse_o, .phase_fine_o, .reg_write_o);
	function automatic logic [78:0] ext_exp();
		return {~bank[1][10], bank[1][11], bank[1][8], bank[1][9], 1'b0, bank[1][12], 2'b11,
			bank[3][15:7], bank[11][15:7], bank[2][15:7], bank[10][15:7], bank[13][15],
			~bank[13][13], bank[13][14], bank[14], bank[15]};
	endfunction
	function automatic logic [78:0] nrm_exp();
		return {pins[4], 1'b0, pins[3:1], 1'b1, pins[0], 37'h0, pins[1], 2'b01, 32'h0};
	endfunction
	task automatic check(input string what, input logic [78:0] got, input logic [78:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic put(input logic [19:0] row, input logic keep);
		int k;
		n = pulses + 1;
		host.send({12'h001, row}, 32, keep);
		bank[row[19:16]] = row[15:0];
		for (k = 0; k < 100 && pulses < n; k++) @(posedge core_clk_i);
		check("write pulse", 79'(pulses), 79'(n));
		if (pulses < n) close_out();
		repeat (2) @(posedge core_clk_i);
	endtask
	task automatic do_reset(input logic mode);
		nrst_i <= 1'b0;
		ext <= mode;
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		foreach (bank[a]) bank[a] = (a % 8 == 2) ? 16'h007f : (a % 8 == 3) ? 16'h807f : 16'h0;
		bank[1] = 16'hb2ff;
		bank[13] = 16'h3fff;
	endtask
	initial begin
		do_reset(1'b1);
		check("ext defaults", seen, ext_exp());
		foreach (rows[r]) begin
			put(rows[r], 1'b0);
			check("ext write", seen, ext_exp());
		end
		put(20'he5555, 1'b1);
		put(20'hf0f0f, 1'b0);
		check("joined frames", seen, ext_exp());
		n = pulses;
		host.send(32'h002e1111, 32, 1'b0);
		host.send(32'h001e2222, 20, 1'b0);
		foreach (resv[a]) host.send({12'h001, resv[a], 16'hffff}, 32, 1'b0);
		@(posedge core_clk_i);
		pins <= 5'h17;
		repeat (20) @(posedge core_clk_i);
		check("refused frames", 79'(pulses), 79'(n));
		check("ext pins", seen, ext_exp());
		put(20'h20155, 1'b0);
		check("after refusal", seen, ext_exp());
		do_reset(1'b0);
		n = pulses;
		host.send(32'h0011ffff, 32, 1'b0);
		repeat (20) @(posedge core_clk_i);
		check("normal frame", 79'(pulses), 79'(n));
		check("normal regs", seen, nrm_exp());
		foreach (pats[p]) begin
			pins <= pats[p];
			repeat (6) @(posedge core_clk_i);
			check("normal pins", seen, nrm_exp());
		end
		close_out();
	end
endmodule
